// File: umh_pkg.sv
package umh_pkg;

   // ==========================================================
   // register byte addresses on the AXI4-Lite slave
   localparam logic [7:0] IER_ADDR        = 8'h04;
   localparam logic [7:0] MODEM_CTRL_ADDR = 8'h10;
   localparam logic [7:0] MODEM_STAT_ADDR = 8'h18;
   localparam logic [7:0] INTSTA_ADDR     = 8'h20;
   localparam logic [7:0] INTMSK_ADDR     = 8'h24;
   localparam int         ADDR_W          = 8;

   // ==========================================================
   // interrupt enable register fields
   localparam int IER_MSI_BIT = 3;

   // ==========================================================
   // modem control register fields
   localparam int CTRL_DTR_BIT  = 0;
   localparam int CTRL_RTS_BIT  = 1;
   localparam int CTRL_OUT1_BIT = 2;
   localparam int CTRL_OUT2_BIT = 3;
   localparam int CTRL_LOOP_BIT = 4;

   // ==========================================================
   // modem status register fields
   localparam int STAT_CTS_CHG_BIT     = 0;
   localparam int STAT_DSR_CHG_BIT     = 1;
   localparam int STAT_RING_TRAIL_BIT  = 2;
   localparam int STAT_CARRIER_CHG_BIT = 3;
   localparam int STAT_CTS_BIT         = 4;
   localparam int STAT_DSR_BIT         = 5;
   localparam int STAT_RING_BIT        = 6;
   localparam int STAT_CARRIER_BIT     = 7;

   // ==========================================================
   // reset values
   localparam logic [7:0] IER_RST    = 8'h00;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [3:0] INTMSK_RST = 4'hf;

   // ==========================================================
   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: umh_modem_handshake.sv
`timescale 1ns/1ps
module umh_modem_handshake (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // axi4-lite write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   // axi4-lite write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // axi4-lite read address
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   // axi4-lite read data
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // modem handshake pins
   input  wire logic        clear_to_send_in_n,
   input  wire logic        data_set_ready_in_n,
   input  wire logic        ring_indicator_in_n,
   input  wire logic        carrier_detect_in_n,
   output logic             request_to_send_out_n,
   output logic             terminal_ready_out_n,
   // interrupt
   output logic             irq
);

   // ==========================================================
   // helpers
   function automatic logic isReg(input logic [7:0] addr, input logic [7:0] reg_addr);
      isReg = (addr == reg_addr);
   endfunction

   function automatic logic isMapped(input logic [7:0] addr);
      isMapped = isReg(addr, umh_pkg::IER_ADDR) | isReg(addr, umh_pkg::MODEM_CTRL_ADDR)
               | isReg(addr, umh_pkg::MODEM_STAT_ADDR) | isReg(addr, umh_pkg::INTSTA_ADDR)
               | isReg(addr, umh_pkg::INTMSK_ADDR);
   endfunction

   // ==========================================================
   // registers
   logic [7:0]  intEnableReg;
   logic [7:0]  modem_control_reg;
   logic [3:0]  deltaFlags;
   logic [3:0]  intStatus;
   logic [3:0]  intMask;

   // ==========================================================
   // pin synchronisers and effective levels
   logic [3:0]  pinSync1;
   logic [3:0]  pinSync2;
   logic [3:0]  lineLevel;
   logic [3:0]  linePrev;
   wire  [3:0]  pinRaw;
   wire  [3:0]  loopLevel;
   wire  [3:0]  next_lineLevel;
   wire         loopMode;

   // order: cts, dsr, ri, dcd
   assign pinRaw    = {carrier_detect_in_n, ring_indicator_in_n, data_set_ready_in_n, clear_to_send_in_n};
   assign loopMode  = modem_control_reg[umh_pkg::CTRL_LOOP_BIT];
   // loopback feeds the status inputs from the control bits instead of the pins
   assign loopLevel = {modem_control_reg[umh_pkg::CTRL_OUT2_BIT], modem_control_reg[umh_pkg::CTRL_OUT1_BIT],
                       modem_control_reg[umh_pkg::CTRL_DTR_BIT], modem_control_reg[umh_pkg::CTRL_RTS_BIT]};
   // status level is the complement of each active-low pin
   assign next_lineLevel = loopMode ? loopLevel : ~pinSync2;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pinSync1  <= 4'hf;
         pinSync2  <= 4'hf;
         lineLevel <= 4'h0;
         linePrev  <= 4'h0;
      end else begin
         pinSync1  <= pinRaw;
         pinSync2  <= pinSync1;
         lineLevel <= next_lineLevel;
         linePrev  <= lineLevel;
      end
   end

   // cts only reaches status and interrupt logic; nothing here can hold off a transmitter
   wire ctsLevel = lineLevel[0];

   // ==========================================================
   // change detection
   wire [3:0] lineEvent;
   assign lineEvent[0] = lineLevel[0] ^ linePrev[0];
   assign lineEvent[1] = lineLevel[1] ^ linePrev[1];
   // ring reports only the pin returning high, i.e. level falling
   assign lineEvent[2] = linePrev[2] & ~lineLevel[2];
   assign lineEvent[3] = lineLevel[3] ^ linePrev[3];

   // ==========================================================
   // axi4-lite write channel
   logic        awHeld;
   logic        wHeld;
   logic [7:0]  awAddr;
   logic [7:0]  wByte;
   logic        wLane0;
   wire         awTake;
   wire         wTake;
   wire         doWrite;
   wire         wrIer;
   wire         wrModemCtrl;
   wire         wrMask;

   assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
   assign awTake        = s_axi_awvalid & s_axi_awready;
   assign wTake         = s_axi_wvalid & s_axi_wready;
   assign doWrite       = awHeld & wHeld;
   // only byte lane 0 carries register bits; other lanes are ignored
   assign wrIer         = doWrite & wLane0 & isReg(awAddr, umh_pkg::IER_ADDR);
   assign wrModemCtrl   = doWrite & wLane0 & isReg(awAddr, umh_pkg::MODEM_CTRL_ADDR);
   assign wrMask        = doWrite & wLane0 & isReg(awAddr, umh_pkg::INTMSK_ADDR);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         awHeld <= 1'b0;
         awAddr <= 8'h00;
      end else if (awTake) begin
         awHeld <= 1'b1;
         awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
         awHeld <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wHeld  <= 1'b0;
         wByte  <= 8'h00;
         wLane0 <= 1'b0;
      end else if (wTake) begin
         wHeld  <= 1'b1;
         wByte  <= s_axi_wdata[7:0];
         wLane0 <= s_axi_wstrb[0];
      end else if (doWrite) begin
         wHeld  <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= umh_pkg::RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= isMapped(awAddr) ? umh_pkg::RESP_OKAY : umh_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // control registers
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         intEnableReg      <= umh_pkg::IER_RST;
         modem_control_reg <= umh_pkg::CTRL_RST;
         intMask           <= umh_pkg::INTMSK_RST;
      end else begin
         if (wrIer) begin
            intEnableReg <= wByte;
         end
         if (wrModemCtrl) begin
            modem_control_reg <= {3'h0, wByte[4:0]};
         end
         if (wrMask) begin
            intMask <= wByte[3:0];
         end
      end
   end

   // ==========================================================
   // axi4-lite read channel
   wire         arTake;
   wire         rdModemStat;
   wire         rdStatus;
   wire  [7:0]  modemStatView;
   wire  [7:0]  readByte;

   assign s_axi_arready = ~s_axi_rvalid;
   assign arTake        = s_axi_arvalid & s_axi_arready;
   assign rdModemStat   = arTake & isReg(s_axi_araddr, umh_pkg::MODEM_STAT_ADDR);
   assign rdStatus      = arTake & isReg(s_axi_araddr, umh_pkg::INTSTA_ADDR);
   assign modemStatView = {lineLevel[3], lineLevel[2], lineLevel[1], ctsLevel, deltaFlags};
   assign readByte      = isReg(s_axi_araddr, umh_pkg::IER_ADDR)        ? intEnableReg
                        : isReg(s_axi_araddr, umh_pkg::MODEM_CTRL_ADDR) ? modem_control_reg
                        : isReg(s_axi_araddr, umh_pkg::MODEM_STAT_ADDR) ? modemStatView
                        : isReg(s_axi_araddr, umh_pkg::INTSTA_ADDR) ? {4'h0, intStatus}
                        : isReg(s_axi_araddr, umh_pkg::INTMSK_ADDR) ? {4'h0, intMask}
                        : 8'h00;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= umh_pkg::RESP_OKAY;
      end else if (arTake) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h000000, readByte};
         s_axi_rresp  <= isMapped(s_axi_araddr) ? umh_pkg::RESP_OKAY : umh_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // change flags and interrupt status; a new event wins over the read clear
   wire [3:0] next_deltaFlags;
   wire [3:0] next_intStatus;
   assign next_deltaFlags = (deltaFlags & ~{4{rdModemStat}}) | lineEvent;
   assign next_intStatus  = (intStatus & ~{4{rdStatus}}) | lineEvent;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         deltaFlags <= 4'h0;
         intStatus  <= 4'h0;
      end else begin
         deltaFlags <= next_deltaFlags;
         intStatus  <= next_intStatus;
      end
   end

   // enable bit 3 gates all modem-status sources; the mask picks among them
   assign irq = intEnableReg[umh_pkg::IER_MSI_BIT] & |(intStatus & intMask);

   // ==========================================================
   // handshake outputs, registered so the pins never glitch on decode
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         request_to_send_out_n <= 1'b1;
         terminal_ready_out_n  <= 1'b1;
      end else begin
         request_to_send_out_n <= ~(modem_control_reg[umh_pkg::CTRL_RTS_BIT] & ~loopMode);
         terminal_ready_out_n  <= ~(modem_control_reg[umh_pkg::CTRL_DTR_BIT] & ~loopMode);
      end
   end

   // ==========================================================
   // checks
   a_cts_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!loopMode)[*4] |-> (modemStatView[umh_pkg::STAT_CTS_BIT] == !$past(clear_to_send_in_n, 3)))
      else $error("cts status not inverse of pin");

   a_dcd_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!loopMode)[*4] |-> (modemStatView[umh_pkg::STAT_CARRIER_BIT] == !$past(carrier_detect_in_n, 3)))
      else $error("dcd status not inverse of pin");

   a_cts_delta: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $changed(ctsLevel) |=> deltaFlags[0])
      else $error("cts change flag missed");

   a_dcd_delta: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $changed(lineLevel[3]) |=> deltaFlags[3])
      else $error("dcd change flag missed");

   a_dsr_delta: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $changed(lineLevel[1]) |=> deltaFlags[1])
      else $error("dsr change flag missed");

   a_ri_trail: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(lineLevel[2]) |=> deltaFlags[2])
      else $error("ring trailing edge missed");

   a_cts_irq: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ($changed(ctsLevel) && intEnableReg[3] && intMask[0] && !wrIer && !wrMask) |=> irq)
      else $error("cts change gave no interrupt");

   a_dcd_irq: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ($changed(lineLevel[3]) && intEnableReg[3] && intMask[3] && !wrIer && !wrMask) |=> irq)
      else $error("dcd change gave no interrupt");

   a_rts_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (modem_control_reg[1] && !loopMode) |=> !request_to_send_out_n)
      else $error("rts not driven low");

   a_rts_reset: assert property (@(posedge clk_sys)
      sys_rst |=> (request_to_send_out_n && terminal_ready_out_n))
      else $error("outputs active after reset");

   a_loop_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
      loopMode |=> (request_to_send_out_n && terminal_ready_out_n))
      else $error("outputs active in loopback");

   a_dtr_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (modem_control_reg[0] && !loopMode) |=> !terminal_ready_out_n)
      else $error("dtr not driven low");

   a_stat_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (rdModemStat && lineEvent == 4'h0) |=> (deltaFlags == 4'h0))
      else $error("status read left change flags");

endmodule

// File: umh_modem_model.sv
`timescale 1ns/1ps
// ==========================================================
// far-side modem: echoes request-to-send as clear-to-send and
// terminal-ready as data-set-ready, after 1 or 8 cycles
module umh_modem_model (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   // from the port
   input  wire logic request_to_send_out_n,
   input  wire logic terminal_ready_out_n,
   // bench controls
   input  wire logic slow,
   input  wire logic ringN,
   input  wire logic carrierN,
   // to the port
   output logic      clear_to_send_in_n,
   output logic      data_set_ready_in_n,
   output logic      ring_indicator_in_n,
   output logic      carrier_detect_in_n
);
   logic [7:0] rtsPipe;
   logic [7:0] dtrPipe;

   // pins idle high, as with the usual pull-ups
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rtsPipe <= 8'hff;
         dtrPipe <= 8'hff;
      end else begin
         rtsPipe <= {rtsPipe[6:0], request_to_send_out_n};
         dtrPipe <= {dtrPipe[6:0], terminal_ready_out_n};
      end
   end

   assign clear_to_send_in_n  = slow ? rtsPipe[7] : rtsPipe[0];
   assign data_set_ready_in_n = slow ? dtrPipe[7] : dtrPipe[0];
   assign ring_indicator_in_n = ringN;
   assign carrier_detect_in_n = carrierN;
endmodule

// File: test_uart_modem_handshake_logic.sv
`timescale 1ns/1ps
module test_uart_modem_handshake_logic;
   // ==========================================================
   // signals
   logic clk_sys = 1'b0, sys_rst = 1'b1, slow = 1'b0, ringN = 1'b1, carrierN = 1'b1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, data;
   logic ctsN, dsrN, riN, dcdN, rtsN, dtrN;
   int fails = 0, nTests = 0;

   always #5 clk_sys = ~clk_sys;

   umh_modem_handshake dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .clear_to_send_in_n(ctsN), .data_set_ready_in_n(dsrN),
      .ring_indicator_in_n(riN), .carrier_detect_in_n(dcdN), .request_to_send_out_n(rtsN),
      .terminal_ready_out_n(dtrN), .irq(irq));

   umh_modem_model modem (.clk_sys(clk_sys), .sys_rst(sys_rst), .request_to_send_out_n(rtsN),
      .terminal_ready_out_n(dtrN), .slow(slow), .ringN(ringN), .carrierN(carrierN),
      .clear_to_send_in_n(ctsN), .data_set_ready_in_n(dsrN), .ring_indicator_in_n(riN),
      .carrier_detect_in_n(dcdN));

   // ==========================================================
   // report
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      nTests++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask

   // ==========================================================
   // axi4-lite master, bounded waits
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
      bit done;
      done = 0;
      @(posedge clk_sys);
      s_axi_awvalid <= 1'b1; s_axi_awaddr <= a; s_axi_wvalid <= 1'b1; s_axi_wdata <= d; s_axi_bready <= 1'b1;
      for (int k = 0; k < 50 && !done; k++) begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            resp = s_axi_bresp; s_axi_bready <= 1'b0; done = 1;
         end
      end
      if (!done) begin
         fails++;
         summarize();
      end
   endtask

   task automatic axiRead(input logic [7:0] a);
      bit done;
      done = 0;
      @(posedge clk_sys);
      s_axi_arvalid <= 1'b1; s_axi_araddr <= a; s_axi_rready <= 1'b1;
      for (int k = 0; k < 50 && !done; k++) begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            data = s_axi_rdata; resp = s_axi_rresp; s_axi_rready <= 1'b0; done = 1;
         end
      end
      if (!done) begin
         fails++;
         summarize();
      end
   endtask

   task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
      axiRead(a);
      chk(what, exp, data);
   endtask

   // pins pass a synchroniser; 16 cycles covers it plus the slow modem
   task automatic settle();
      repeat (16) @(posedge clk_sys);
   endtask

   // ==========================================================
   // tests
   initial begin
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      rdChk("ier", umh_pkg::IER_ADDR, 32'h0);
      rdChk("modem ctrl", umh_pkg::MODEM_CTRL_ADDR, 32'h0);
      rdChk("mask", umh_pkg::INTMSK_ADDR, 32'hf);
      rdChk("modem status", umh_pkg::MODEM_STAT_ADDR, 32'h0);
      chk("rts", 32'h1, rtsN);
      chk("dtr", 32'h1, dtrN);
      $display("test reset done");

      axiWrite(umh_pkg::MODEM_CTRL_ADDR, 32'h02);
      settle();
      chk("rts", 32'h0, rtsN);
      chk("irq", 32'h0, irq);
      rdChk("modem status", umh_pkg::MODEM_STAT_ADDR, 32'h11);
      rdChk("modem status", umh_pkg::MODEM_STAT_ADDR, 32'h10);
      rdChk("intsta", umh_pkg::INTSTA_ADDR, 32'h1);
      $display("test clear to send done");

      axiWrite(umh_pkg::IER_ADDR, 32'h08);
      carrierN <= 1'b0;
      settle();
      chk("irq", 32'h1, irq);
      rdChk("modem status", umh_pkg::MODEM_STAT_ADDR, 32'h98);
      rdChk("intsta", umh_pkg::INTSTA_ADDR, 32'h8);
      chk("irq", 32'h0, irq);
      $display("test carrier done");

      // slow modem: the answer arrives eight cycles late
      slow <= 1'b1;
      axiWrite(umh_pkg::MODEM_CTRL_ADDR, 32'h03);
      settle();
      chk("dtr", 32'h0, dtrN);
      chk("irq", 32'h1, irq);
      rdChk("modem status", umh_pkg::MODEM_STAT_ADDR, 32'hb2);
      rdChk("intsta", umh_pkg::INTSTA_ADDR, 32'h2);
      $display("test data set ready done");

      ringN <= 1'b0;
      settle();
      rdChk("modem status", umh_pkg::MODEM_STAT_ADDR, 32'hf0);
      ringN <= 1'b1;
      settle();
      rdChk("modem status", umh_pkg::MODEM_STAT_ADDR, 32'hb4);
      rdChk("intsta", umh_pkg::INTSTA_ADDR, 32'h4);
      $display("test ring done");

      axiWrite(umh_pkg::INTMSK_ADDR, 32'h0);
      carrierN <= 1'b1;
      settle();
      chk("irq", 32'h0, irq);
      rdChk("modem status", umh_pkg::MODEM_STAT_ADDR, 32'h38);
      axiWrite(umh_pkg::INTMSK_ADDR, 32'hf);
      chk("irq", 32'h1, irq);
      rdChk("intsta", umh_pkg::INTSTA_ADDR, 32'h8);
      $display("test mask done");

      axiWrite(umh_pkg::MODEM_CTRL_ADDR, 32'h13);
      settle();
      chk("rts", 32'h1, rtsN);
      chk("dtr", 32'h1, dtrN);
      axiWrite(umh_pkg::MODEM_CTRL_ADDR, 32'h03);
      settle();
      chk("rts", 32'h0, rtsN);
      $display("test loopback done");

      @(posedge clk_sys);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      chk("rts", 32'h1, rtsN);
      chk("dtr", 32'h1, dtrN);
      rdChk("modem ctrl", umh_pkg::MODEM_CTRL_ADDR, 32'h0);
      $display("test second reset done");

      rdChk("unmapped", 8'h30, 32'h0);
      chk("rresp", {30'h0, umh_pkg::RESP_SLVERR}, {30'h0, resp});
      axiWrite(8'h30, 32'h5);
      chk("bresp", {30'h0, umh_pkg::RESP_SLVERR}, {30'h0, resp});
      // a write without byte lane 0 is answered but changes nothing
      s_axi_wstrb <= 4'h0;
      axiWrite(umh_pkg::MODEM_CTRL_ADDR, 32'h02);
      chk("bresp", {30'h0, umh_pkg::RESP_OKAY}, {30'h0, resp});
      rdChk("modem ctrl", umh_pkg::MODEM_CTRL_ADDR, 32'h0);
      chk("rresp", {30'h0, umh_pkg::RESP_OKAY}, {30'h0, resp});
      s_axi_wstrb <= 4'hf;
      $display("test unmapped done");
      summarize();
   end
endmodule
